// [logic/ubb_defs.svh]
// constants of the usb serial bus bridge command interpreter
// assumes a 250 MHz controller clock; included by the engine, bridge and check modules
`ifndef UBB_DEFS_SVH
`define UBB_DEFS_SVH

`define UBB_OP_WRITE 8'h10
`define UBB_OP_BIT 4
`define UBB_INTF_GPIO 4'h8
`define UBB_INTF_SPI16 4'h4
`define UBB_INTF_FAST 4'h2
`define UBB_INTF_STD 4'h1
`define UBB_INTF_SPI8 4'h0
`define UBB_ST_REQ_ERR 8'h80
`define UBB_ST_BUS_ERR 8'h40
`define UBB_ST_DONE 8'h20
`define UBB_PKT_MAX 7'h40
`define UBB_DATA_MAX 8'h3c
`define UBB_HDR_LEN 7'h04
`define UBB_GPIO_W 7

`define UBB_CLK_NS 4
`define UBB_STD_QTR_NS 2500
`define UBB_FAST_QTR_NS 625
`define UBB_STD_QTR_CYC \
   ((`UBB_STD_QTR_NS + `UBB_CLK_NS - 1) / `UBB_CLK_NS)
`define UBB_FAST_QTR_CYC \
   ((`UBB_FAST_QTR_NS + `UBB_CLK_NS - 1) / `UBB_CLK_NS)

`endif

// [logic/ubb_pkg.sv]
// types shared by the bridge controller and its serial engine
// assumes nothing beyond the constants header
package ubb_pkg;
   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_DECODE = 11'h002,
      ST_BEGIN = 11'h004,
      ST_HDR1 = 11'h008,
      ST_HDR3 = 11'h010,
      ST_RESTART = 11'h020,
      ST_ADDR_RD = 11'h040,
      ST_DATA = 11'h080,
      ST_FINISH = 11'h100,
      ST_WAIT = 11'h200,
      ST_RESP = 11'h400
   } ubb_state_type;

   typedef enum logic [1:0] {
      CMD_START = 2'h1,
      CMD_STOP = 2'h2,
      CMD_BYTE = 2'h3
   } ubb_cmd_type;
endpackage

// [logic/ubb_eng_if.sv]
// link between the command sequencer and the serial bit engine
// assumes both ends share one clock
`timescale 1ns/1ps
interface ubb_eng_if;
   import ubb_pkg::*;
   logic start;
   ubb_cmd_type cmd;
   logic spi;
   logic fast;
   logic rd;
   logic last;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic done;
   logic nack;
   modport ctrl(output start, cmd, spi, fast, rd, last, wdata,
      input rdata, done, nack);
   modport eng(input start, cmd, spi, fast, rd, last, wdata,
      output rdata, done, nack);
endinterface

// [logic/ubb_serial.sv]
// serial bit engine: two-wire start, stop and byte, or spi byte shift
// assumes pins arrive unsynchronised; one command at a time
`timescale 1ns/1ps
`include "ubb_defs.svh"
module ubb_serial import ubb_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // sequencer side
   ubb_eng_if.eng e,
   // two-wire pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oen,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oen,
   // spi pins
   input wire logic miso_in,
   output logic sclk,
   output logic mosi,
   output logic cs_n
);
   logic [9:0] cnt;
   logic tick;
   logic [2:0] s1, s2, s3, lvl;
   logic busy, rd, done, nack, hold, bitv;
   ubb_cmd_type cmd;
   logic [1:0] q;
   logic [3:0] bitn;
   logic [8:0] tx;
   logic [7:0] rx;

   assign e.done = done;
   assign e.nack = nack;
   assign e.rdata = rx;
   assign tick = (cnt == 10'h000);
   // clock stretching: a quarter waits while a target holds scl low
   assign hold = !e.spi && q == 2'h2 && !lvl[1];
   assign bitv = e.spi ? lvl[2] : lvl[0];

   // quarter-bit enable; spi shares the fast rate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 10'h000;
      end else if (tick) begin
         cnt <= (e.spi || e.fast) ? 10'(`UBB_FAST_QTR_CYC - 1) :
            10'(`UBB_STD_QTR_CYC - 1);
      end else begin
         cnt <= cnt - 10'h001;
      end
   end

   // {miso, scl, sda}; a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= 3'h3;
         s2 <= 3'h3;
         s3 <= 3'h3;
         lvl <= 3'h3;
      end else begin
         s1 <= {miso_in, scl_in, sda_in};
         s2 <= s1;
         s3 <= s2;
         lvl <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
         rd <= 1'b0;
         cmd <= CMD_START;
         q <= 2'h0;
         bitn <= 4'h0;
         tx <= 9'h1ff;
         rx <= 8'h00;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oen <= 1'b1;
         sda_oen <= 1'b1;
         sclk <= 1'b0;
         mosi <= 1'b0;
         cs_n <= 1'b1;
      end else begin
         done <= 1'b0;
         if (!busy) begin
            if (e.start) begin
               busy <= 1'b1;
               cmd <= e.cmd;
               rd <= e.rd;
               q <= 2'h0;
               bitn <= 4'h0;
               nack <= 1'b0;
               // read: release data, then ack unless it is the last byte
               tx <= e.rd ? {8'hff, e.last} : {e.wdata, 1'b1};
            end
         end else if (tick && !hold) begin
            q <= q + 2'h1;
            case (cmd)
               CMD_START: begin
                  if (e.spi) begin
                     sclk <= 1'b0;
                     cs_n <= 1'b0;
                  end else if (q == 2'h0) begin
                     sda_oen <= 1'b1;
                  end else if (q == 2'h1) begin
                     scl_oen <= 1'b1;
                  end else if (q == 2'h2) begin
                     sda_oen <= 1'b0;
                  end else begin
                     scl_oen <= 1'b0;
                  end
                  if (q == 2'h3) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                  end
               end
               CMD_STOP: begin
                  if (e.spi) begin
                     sclk <= 1'b0;
                     cs_n <= 1'b1;
                  end else if (q == 2'h0) begin
                     sda_oen <= 1'b0;
                  end else if (q == 2'h1) begin
                     scl_oen <= 1'b1;
                  end else if (q == 2'h2) begin
                     sda_oen <= 1'b1;
                  end
                  if (q == 2'h3) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                  end
               end
               CMD_BYTE: begin
                  if (q == 2'h0) begin
                     if (e.spi) begin
                        mosi <= tx[8];
                     end else begin
                        sda_oen <= tx[8];
                     end
                  end else if (q == 2'h1) begin
                     if (e.spi) begin
                        sclk <= 1'b1;
                     end else begin
                        scl_oen <= 1'b1;
                     end
                  end else if (q == 2'h2) begin
                     if (!e.spi && bitn == 4'h8) begin
                        nack <= !rd && bitv;
                     end else begin
                        rx <= {rx[6:0], bitv};
                     end
                  end else begin
                     if (e.spi) begin
                        sclk <= 1'b0;
                     end else begin
                        scl_oen <= 1'b0;
                     end
                     tx <= {tx[7:0], 1'b1};
                     bitn <= bitn + 4'h1;
                     if (bitn == (e.spi ? 4'h7 : 4'h8)) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                     end
                  end
               end
               default: begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule

// [logic/ubb_bridge.sv]
// bridge command interpreter: request packet in, bus transaction,
// status packet out
// assumes the usb core delivers each control-endpoint report as a byte
// stream and drains the interrupt-endpoint reply as a byte stream
//
// How it works
// - byte 0 splits into operation and interface
// - interface code picks gpio, spi or two-wire
// - byte 1 is target address or address msb
// - byte 2 counts the data bytes
// - byte 3 is register address or its lsb
// - reply byte 0 is request byte 0 plus status
// - spi reply bytes 1 and 3 carry sampled input
// - reply echoes length and data, or read data
// - clean completion sets the done flag
// - bus failure sets the bus error flag
// - undefined byte 0 returns request error
// - read returns consecutive registers from byte 4
// - gpio code ignores bytes 1 and 3
// - gpio byte maps port3 and port1 lines
// - gpio read returns present line states
`timescale 1ns/1ps
`include "ubb_defs.svh"
module ubb_bridge import ubb_pkg::*; (
   // clock and reset
   input wire logic MCLK,
   input wire logic RESETN,
   // request stream from the control endpoint
   input wire logic REQ_VALID,
   input wire logic [7:0] REQ_DATA,
   input wire logic REQ_LAST,
   output logic REQ_READY,
   // reply stream to the interrupt endpoint
   output logic RSP_VALID,
   output logic [7:0] RSP_DATA,
   output logic RSP_LAST,
   input wire logic RSP_READY,
   // two-wire bus, open drain
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OEN,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OEN,
   // spi bus
   output logic SPI_SCLK,
   output logic SPI_MOSI,
   input wire logic SPI_MISO,
   output logic SPI_CS_N,
   // general-purpose lines {port3_line5..3, port1_line3..0}
   input wire logic [`UBB_GPIO_W-1:0] GPIO_IN,
   output logic [`UBB_GPIO_W-1:0] GPIO_OUT
);
   ubb_eng_if e();
   ubb_state_type state, resume;
   logic [7:0] pkt [0:63];
   logic [6:0] rx_cnt, rsp_cnt, rsp_len;
   logic [5:0] idx, store_idx;
   logic store, step, fail;
   logic [7:0] status;
   logic start;
   ubb_cmd_type cmd;
   logic rd_flag, last_flag;
   logic [7:0] wdata;
   logic [`UBB_GPIO_W-1:0] g1, g2, g3, gpio_lvl;
   logic [3:0] intf;
   logic is_rd, is_spi, is_i2c, is_gpio, req_bad;
   logic [7:0] len;
   logic take_req, take_rsp;

   function automatic logic known_intf(input logic [3:0] code);
      known_intf = code == `UBB_INTF_GPIO || code == `UBB_INTF_SPI16 ||
         code == `UBB_INTF_FAST || code == `UBB_INTF_STD ||
         code == `UBB_INTF_SPI8;
   endfunction

   assign intf = pkt[0][3:0];
   assign is_rd = !pkt[0][`UBB_OP_BIT];
   assign is_gpio = intf == `UBB_INTF_GPIO;
   assign is_spi = intf == `UBB_INTF_SPI16 || intf == `UBB_INTF_SPI8;
   assign is_i2c = !is_gpio && !is_spi;
   assign len = pkt[2];
   // short packets and overlong lengths are treated as malformed too
   assign req_bad = pkt[0][7:5] != 3'h0 || !known_intf(intf) ||
      rx_cnt < `UBB_HDR_LEN || len > `UBB_DATA_MAX ||
      (!is_rd && !is_gpio && rx_cnt < `UBB_HDR_LEN + len[6:0]);
   assign take_req = REQ_VALID && REQ_READY;
   assign take_rsp = RSP_VALID && RSP_READY;

   assign e.start = start;
   assign e.cmd = cmd;
   assign e.spi = is_spi;
   assign e.fast = intf == `UBB_INTF_FAST;
   assign e.rd = rd_flag;
   assign e.last = last_flag;
   assign e.wdata = wdata;

   ubb_serial u_serial (
      .clk(MCLK),
      .rst_n(RESETN),
      .e(e),
      .scl_in(SCL_I),
      .scl_out(SCL_O),
      .scl_oen(SCL_OEN),
      .sda_in(SDA_I),
      .sda_out(SDA_O),
      .sda_oen(SDA_OEN),
      .miso_in(SPI_MISO),
      .sclk(SPI_SCLK),
      .mosi(SPI_MOSI),
      .cs_n(SPI_CS_N)
   );

   // sequencer
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= ST_IDLE;
         resume <= ST_IDLE;
         start <= 1'b0;
         cmd <= CMD_START;
         rd_flag <= 1'b0;
         last_flag <= 1'b0;
         wdata <= 8'h00;
         idx <= 6'h00;
         store <= 1'b0;
         store_idx <= 6'h00;
         step <= 1'b0;
         fail <= 1'b0;
         status <= 8'h00;
         rsp_len <= 7'h00;
      end else begin
         start <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (take_req && REQ_LAST) begin
                  state <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               fail <= 1'b0;
               idx <= 6'h00;
               rsp_len <= req_bad ? rx_cnt :
                  `UBB_HDR_LEN + len[6:0];
               if (req_bad) begin
                  status <= `UBB_ST_REQ_ERR;
                  state <= ST_RESP;
               end else if (is_gpio) begin
                  status <= `UBB_ST_DONE;
                  state <= ST_RESP;
               end else begin
                  state <= ST_BEGIN;
               end
            end
            ST_BEGIN: begin
               start <= 1'b1;
               cmd <= CMD_START;
               store <= 1'b0;
               step <= 1'b0;
               rd_flag <= 1'b0;
               state <= ST_WAIT;
               resume <= ST_HDR1;
            end
            ST_HDR1: begin
               start <= 1'b1;
               cmd <= CMD_BYTE;
               wdata <= is_spi ? pkt[1] : {pkt[1][7:1], 1'b0};
               store <= is_spi;
               store_idx <= 6'h01;
               state <= ST_WAIT;
               resume <= ST_HDR3;
            end
            ST_HDR3: begin
               start <= 1'b1;
               cmd <= CMD_BYTE;
               wdata <= pkt[3];
               store <= is_spi;
               store_idx <= 6'h03;
               state <= ST_WAIT;
               resume <= (is_i2c && is_rd) ? ST_RESTART : ST_DATA;
            end
            ST_RESTART: begin
               start <= 1'b1;
               cmd <= CMD_START;
               store <= 1'b0;
               state <= ST_WAIT;
               resume <= ST_ADDR_RD;
            end
            ST_ADDR_RD: begin
               start <= 1'b1;
               cmd <= CMD_BYTE;
               wdata <= {pkt[1][7:1], 1'b1};
               state <= ST_WAIT;
               resume <= ST_DATA;
            end
            ST_DATA: begin
               if ({2'h0, idx} == len) begin
                  state <= ST_FINISH;
               end else begin
                  start <= 1'b1;
                  cmd <= CMD_BYTE;
                  rd_flag <= is_rd && is_i2c;
                  last_flag <= {2'h0, idx} + 8'h01 == len;
                  wdata <= is_rd ? 8'h00 : pkt[6'h04 + idx];
                  store <= is_rd;
                  store_idx <= 6'h04 + idx;
                  step <= 1'b1;
                  state <= ST_WAIT;
                  resume <= ST_DATA;
               end
            end
            ST_FINISH: begin
               start <= 1'b1;
               cmd <= CMD_STOP;
               store <= 1'b0;
               step <= 1'b0;
               status <= fail ? `UBB_ST_BUS_ERR : `UBB_ST_DONE;
               state <= ST_WAIT;
               resume <= ST_RESP;
            end
            ST_WAIT: begin
               if (e.done) begin
                  if (step) begin
                     idx <= idx + 6'h01;
                  end
                  if (e.nack && cmd == CMD_BYTE && !is_spi) begin
                     fail <= 1'b1;
                     state <= ST_FINISH;
                  end else begin
                     state <= resume;
                  end
               end
            end
            ST_RESP: begin
               if (take_rsp && RSP_LAST) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // packet store: request bytes, captured bus data, gpio sample
   always_ff @(posedge MCLK) begin
      if (state == ST_IDLE && take_req && rx_cnt < `UBB_PKT_MAX) begin
         pkt[rx_cnt[5:0]] <= REQ_DATA;
      end else if (state == ST_WAIT && e.done && store) begin
         pkt[store_idx] <= e.rdata;
      end else if (state == ST_DECODE && !req_bad && is_gpio && is_rd) begin
         pkt[4] <= {1'b0, gpio_lvl};
      end
   end

   // request intake
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         REQ_READY <= 1'b0;
         rx_cnt <= 7'h00;
      end else if (state == ST_IDLE) begin
         REQ_READY <= !(take_req && REQ_LAST);
         if (take_req && rx_cnt < `UBB_PKT_MAX) begin
            rx_cnt <= rx_cnt + 7'h01;
         end
      end else begin
         REQ_READY <= 1'b0;
         if (state == ST_RESP) begin
            rx_cnt <= 7'h00;
         end
      end
   end

   // reply stream; byte 0 carries request byte 0 with the status flags
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         RSP_VALID <= 1'b0;
         RSP_DATA <= 8'h00;
         RSP_LAST <= 1'b0;
         rsp_cnt <= 7'h00;
      end else if (state == ST_RESP && !RSP_VALID) begin
         RSP_VALID <= 1'b1;
         RSP_DATA <= pkt[0] | status;
         RSP_LAST <= rsp_len == 7'h01;
         rsp_cnt <= 7'h01;
      end else if (take_rsp) begin
         if (RSP_LAST) begin
            RSP_VALID <= 1'b0;
            RSP_LAST <= 1'b0;
         end else begin
            RSP_DATA <= pkt[rsp_cnt[5:0]];
            RSP_LAST <= rsp_cnt + 7'h01 == rsp_len;
            rsp_cnt <= rsp_cnt + 7'h01;
         end
      end
   end

   // gpio lines; bit 7 of the data byte is unused
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         g1 <= '0;
         g2 <= '0;
         g3 <= '0;
         gpio_lvl <= '0;
         GPIO_OUT <= '0;
      end else begin
         g1 <= GPIO_IN;
         g2 <= g1;
         g3 <= g2;
         gpio_lvl <= (~(g2 ^ g3) & g3) | ((g2 ^ g3) & gpio_lvl);
         if (state == ST_DECODE && !req_bad && is_gpio && !is_rd) begin
            GPIO_OUT <= pkt[4][`UBB_GPIO_W-1:0];
         end
      end
   end
endmodule

// [test/ubb_bridge_asserts.sv]
// port-level checks of the bridge: stream handshakes, reply status, buses
// assumes one clock domain, MCLK, with RESETN active low
`timescale 1ns/1ps
`include "ubb_defs.svh"
module ubb_bridge_asserts (
   // clock and reset
   input wire logic MCLK,
   input wire logic RESETN,
   // request and reply streams
   input wire logic REQ_VALID,
   input wire logic [7:0] REQ_DATA,
   input wire logic REQ_LAST,
   input wire logic REQ_READY,
   input wire logic RSP_VALID,
   input wire logic [7:0] RSP_DATA,
   input wire logic RSP_LAST,
   input wire logic RSP_READY,
   // bus pins
   input wire logic SCL_O,
   input wire logic SCL_OEN,
   input wire logic SDA_O,
   input wire logic SDA_OEN,
   input wire logic SPI_SCLK,
   input wire logic SPI_CS_N,
   input wire logic [`UBB_GPIO_W-1:0] GPIO_OUT
);
   logic [7:0] req0;
   logic req_first;
   logic [6:0] rsp_cnt;
   logic scl_q;
   logic [8:0] scl_gap;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         req0 <= 8'h00;
         req_first <= 1'b1;
      end else if (REQ_VALID && REQ_READY) begin
         if (req_first) req0 <= REQ_DATA;
         req_first <= REQ_LAST;
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) rsp_cnt <= 7'h00;
      else if (RSP_VALID && RSP_READY) rsp_cnt <= RSP_LAST ? 7'h00 :
         rsp_cnt + 7'h01;
   end
   // saturating gap between clock-line edges; quarters are 157 at least
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         scl_q <= 1'b1;
         scl_gap <= 9'h1ff;
      end else begin
         scl_q <= SCL_OEN;
         if (SCL_OEN != scl_q) scl_gap <= 9'h000;
         else if (scl_gap != 9'h1ff) scl_gap <= scl_gap + 9'h001;
      end
   end
   sequence last_taken;
      REQ_VALID && REQ_READY && REQ_LAST;
   endsequence
   sequence reply_ended;
      RSP_VALID && RSP_READY && RSP_LAST;
   endsequence
   a_ready_drops: assert property (last_taken |=> !REQ_READY)
      else $error("request still accepted after last byte");
   a_reply_after_bus: assert property (RSP_VALID |-> !REQ_READY &&
      SPI_CS_N && SCL_OEN && SDA_OEN) else $error("reply during bus work");
   a_ready_returns: assert property (reply_ended |=>
      !RSP_VALID ##[0:2] REQ_READY) else $error("no return to idle");
   a_reply_holds: assert property (RSP_VALID && !RSP_READY |=>
      RSP_VALID && $stable(RSP_DATA) && $stable(RSP_LAST))
      else $error("reply byte changed while stalled");
   a_status_merge: assert property (RSP_VALID && rsp_cnt == 7'h00 |->
      (RSP_DATA & req0) == req0 &&
      (RSP_DATA & ~req0) inside {8'h20, 8'h40, 8'h80})
      else $error("reply byte 0 is not request byte 0 with one status");
   a_reply_bounded: assert property (reply_ended |->
      rsp_cnt <= 7'h3f) else $error("reply longer than 64 bytes");
   a_sclk_idle: assert property (SPI_CS_N |-> !SPI_SCLK)
      else $error("serial clock moves while deselected");
   a_one_bus: assert property (!SPI_CS_N |-> SCL_OEN && SDA_OEN)
      else $error("two buses active at once");
   a_drain_only: assert property (!SCL_O && !SDA_O)
      else $error("open-drain line driven high");
   a_gpio_quiet: assert property (!$stable(GPIO_OUT) |->
      !REQ_READY && !RSP_VALID) else $error("lines changed outside a write");
   a_scl_rate: assert property (SCL_OEN != scl_q |->
      scl_gap >= 9'h096) else $error("two-wire clock edge too early");
endmodule

bind ubb_bridge ubb_bridge_asserts chk (.MCLK(MCLK), .RESETN(RESETN),
   .REQ_VALID(REQ_VALID), .REQ_DATA(REQ_DATA), .REQ_LAST(REQ_LAST),
   .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
   .RSP_LAST(RSP_LAST), .RSP_READY(RSP_READY), .SCL_O(SCL_O),
   .SCL_OEN(SCL_OEN), .SDA_O(SDA_O), .SDA_OEN(SDA_OEN),
   .SPI_SCLK(SPI_SCLK), .SPI_CS_N(SPI_CS_N), .GPIO_OUT(GPIO_OUT));

// [test/ubb_host.sv]
// host model: offers one request packet, then drains its reply packet
// assumes the bench fills req before each run
`timescale 1ns/1ps
module ubb_host (
   // clock
   input wire logic MCLK,
   // request stream
   output logic REQ_VALID,
   output logic [7:0] REQ_DATA,
   output logic REQ_LAST,
   input wire logic REQ_READY,
   // reply stream
   input wire logic RSP_VALID,
   input wire logic [7:0] RSP_DATA,
   input wire logic RSP_LAST,
   output logic RSP_READY
);
   logic [7:0] req[$];
   logic [7:0] rsp[$];
   initial begin
      REQ_VALID = 1'b0;
      REQ_DATA = 8'h00;
      REQ_LAST = 1'b0;
      RSP_READY = 1'b0;
   end
   // one packet is one report-set transfer; bench keeps it short
   task automatic run(input bit slow, output int cyc,
      output bit ok);
      int n;
      ok = 1'b1;
      rsp.delete();
      foreach (req[i]) begin
         REQ_VALID <= 1'b1;
         REQ_DATA <= req[i];
         REQ_LAST <= (i == req.size() - 1);
         n = 0;
         do begin
            @(posedge MCLK);
            n++;
         end while (REQ_READY !== 1'b1 && n < 100);
         if (REQ_READY !== 1'b1) ok = 1'b0;
      end
      // released data shows no stale byte
      REQ_VALID <= 1'b0;
      REQ_LAST <= 1'b0;
      REQ_DATA <= ~req[req.size() - 1];
      if (ok) RSP_READY <= 1'b1;
      n = 0;
      while (ok && n < 40000) begin
         @(posedge MCLK);
         n++;
         if (RSP_VALID === 1'b1 && RSP_READY === 1'b1) begin
            rsp.push_back(RSP_DATA);
            if (RSP_LAST === 1'b1) break;
         end
         if (n < 40000) RSP_READY <= slow ? ~RSP_READY : 1'b1;
      end
      if (n >= 40000) ok = 1'b0;
      RSP_READY <= 1'b0;
      cyc = n;
   endtask
endmodule

// [test/test_usb_serial_bus_bridge_cmd.sv]
// self-checking bench of the bridge: table of packets, then bus faults
// assumes no target on the two-wire bus, inverted loopback on spi
`timescale 1ns/1ps
`define CHK(a, e) begin \
   checks_done++; \
   if ((a) !== (e)) begin \
      mismatches++; \
      $display("ERROR %0t: got %h expected %h", $time, (a), (e)); \
   end \
end
module test_usb_serial_bus_bridge_cmd;
   typedef struct {
      logic [7:0] b0, b1, len, b3, d;
      int n;
      logic [7:0] e0, e1, e3, e4;
      int rl;
      logic [6:0] g;
   } ubb_row_type;
   logic MCLK = 1'b0;
   logic RESETN = 1'b0;
   logic req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
   logic [7:0] req_data, rsp_data;
   logic scl_o, scl_oen, sda_o, sda_oen, sclk, mosi, cs_n;
   logic [6:0] gpio_in = 7'h35;
   logic [6:0] gpio_out;
   int mismatches = 0;
   int checks_done = 0;
   // pull-ups on both two-wire lines, nobody answers
   wire scl_line = scl_oen | scl_o;
   wire sda_line = sda_oen | sda_o;
   // selected, the line flips so a stale sample shows up
   wire miso = cs_n ? mosi : ~mosi;
   // rows: request bytes, count sent, expected reply bytes, length, lines
   ubb_row_type rows [6] = '{
      '{8'h18, 8'ha5, 8'h01, 8'h5a, 8'h40, 5, 8'h38, 8'ha5, 8'h5a, 8'h40,
         5, 7'h40},
      '{8'h08, 8'h00, 8'h01, 8'h00, 8'h00, 4, 8'h28, 8'h00, 8'h00, 8'h35,
         5, 7'h40},
      '{8'h10, 8'ha0, 8'h01, 8'h05, 8'haa, 5, 8'h30, 8'h5f, 8'hfa, 8'haa,
         5, 7'h40},
      '{8'h04, 8'h10, 8'h01, 8'he0, 8'h00, 4, 8'h24, 8'hef, 8'h1f, 8'hff,
         5, 7'h40},
      '{8'h13, 8'ha0, 8'h01, 8'h05, 8'haa, 5, 8'h93, 8'ha0, 8'h05, 8'haa,
         5, 7'h40},
      '{8'h0c, 8'h00, 8'h01, 8'h00, 8'h00, 4, 8'h8c, 8'h00, 8'h00, 8'h00,
         4, 7'h40}};
   always #2 MCLK = ~MCLK;
   ubb_bridge dut (.MCLK(MCLK), .RESETN(RESETN), .REQ_VALID(req_valid),
      .REQ_DATA(req_data), .REQ_LAST(req_last), .REQ_READY(req_ready),
      .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_LAST(rsp_last),
      .RSP_READY(rsp_ready), .SCL_I(scl_line), .SCL_O(scl_o),
      .SCL_OEN(scl_oen), .SDA_I(sda_line), .SDA_O(sda_o),
      .SDA_OEN(sda_oen), .SPI_SCLK(sclk), .SPI_MOSI(mosi),
      .SPI_MISO(miso), .SPI_CS_N(cs_n), .GPIO_IN(gpio_in),
      .GPIO_OUT(gpio_out));
   ubb_host host (.MCLK(MCLK), .REQ_VALID(req_valid), .REQ_DATA(req_data),
      .REQ_LAST(req_last), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
      .RSP_DATA(rsp_data), .RSP_LAST(rsp_last), .RSP_READY(rsp_ready));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic do_run(input bit slow, output int cyc);
      bit ok;
      host.run(slow, cyc, ok);
      if (!ok) begin
         mismatches++;
         $display("ERROR %0t: stream wait ran out", $time);
         give_verdict();
      end
   endtask
   initial begin
      int cyc_fast;
      int cyc_std;
      int cyc;
      ubb_row_type r;
      repeat (5) @(posedge MCLK);
      `CHK(req_ready, 1'b0)
      `CHK(cs_n, 1'b1)
      `CHK(scl_oen & sda_oen, 1'b1)
      `CHK(gpio_out, 7'h00)
      RESETN <= 1'b1;
      repeat (3) @(posedge MCLK);
      // every row sends length one, read rows send only four bytes
      foreach (rows[k]) begin
         r = rows[k];
         host.req = '{r.b0, r.b1, r.len, r.b3};
         if (r.n > 4) host.req.push_back(r.d);
         do_run(k[0], cyc);
         `CHK(host.rsp.size(), r.rl)
         `CHK(host.rsp[0], r.e0)
         `CHK(host.rsp[1], r.e1)
         `CHK(host.rsp[2], r.len)
         `CHK(host.rsp[3], r.e3)
         if (r.rl > 4) `CHK(host.rsp[4], r.e4)
         `CHK(gpio_out, r.g)
      end
      // no target acknowledges: fast write, then standard read
      host.req = '{8'h12, 8'ha0, 8'h01, 8'h05, 8'haa};
      do_run(1'b1, cyc_fast);
      `CHK(host.rsp[0], 8'h52)
      `CHK(host.rsp[4], 8'haa)
      host.req = '{8'h01, 8'ha0, 8'h01, 8'h05};
      do_run(1'b0, cyc_std);
      `CHK(host.rsp[0], 8'h41)
      `CHK(cyc_std > 3 * cyc_fast, 1'b1)
      // second reset clears the written lines
      RESETN <= 1'b0;
      repeat (2) @(posedge MCLK);
      `CHK(gpio_out, 7'h00)
      RESETN <= 1'b1;
      repeat (3) @(posedge MCLK);
      // new line levels prove the read is live, not a stale copy
      gpio_in <= 7'h4a;
      host.req = '{8'h08, 8'h00, 8'h01, 8'h00};
      do_run(1'b0, cyc);
      `CHK(host.rsp[4], 8'h4a)
      give_verdict();
   end
endmodule
